// file: hw/tmwm_consts.vh
// constants for the 8-bit timer waveform block: register map, field
// positions, mode codes and reset values
// assumes an APB slave with 32-bit data, one aligned word per register
`ifndef TMWM_CONSTS_VH
`define TMWM_CONSTS_VH

// ==========================================
// register byte offsets
`define TMWM_OFF_CTRL      12'h000
`define TMWM_OFF_COUNT     12'h004
`define TMWM_OFF_CMPA      12'h008
`define TMWM_OFF_CMPB      12'h00C
`define TMWM_OFF_FLAGS     12'h010
`define TMWM_OFF_DIR       12'h014
`define TMWM_OFF_WAVE      12'h018

// ==========================================
// control fields
`define TMWM_CTRL_MODE_LO  0
`define TMWM_CTRL_MODE_HI  2
`define TMWM_CTRL_PRE_LO   4
`define TMWM_CTRL_PRE_HI   6
`define TMWM_CTRL_ACTB_LO  8
`define TMWM_CTRL_ACTB_HI  9
`define TMWM_CTRL_ACTA_LO  10
`define TMWM_CTRL_ACTA_HI  11

// ==========================================
// flag bits
`define TMWM_FLG_OVF       0
`define TMWM_FLG_CMPA      1
`define TMWM_FLG_CMPB      2

// ==========================================
// wave mode codes
`define TMWM_MODE_NORMAL   3'h0
`define TMWM_MODE_PC_FF    3'h1
`define TMWM_MODE_CTC      3'h2
`define TMWM_MODE_FAST_FF  3'h3
`define TMWM_MODE_PC_CA    3'h5
`define TMWM_MODE_FAST_CA  3'h7

// ==========================================
// output actions
`define TMWM_ACT_NONE      2'h0
`define TMWM_ACT_TOGGLE    2'h1
`define TMWM_ACT_CLEAR     2'h2
`define TMWM_ACT_SET       2'h3

// ==========================================
// prescaler selections and divisor masks (divisor minus one)
`define TMWM_PRE_STOP      3'h0
`define TMWM_PRE_1         3'h1
`define TMWM_PRE_8         3'h2
`define TMWM_PRE_64        3'h3
`define TMWM_PRE_256       3'h4
`define TMWM_PRE_1024      3'h5
`define TMWM_DIV_8         10'h007
`define TMWM_DIV_64        10'h03F
`define TMWM_DIV_256       10'h0FF
`define TMWM_DIV_1024      10'h3FF

// ==========================================
// count values
`define TMWM_BOTTOM        8'h00
`define TMWM_MAX           8'hFF
`define TMWM_ZERO32        32'h0000_0000

`endif

// file: hw/tmwm_timer.v
// 8-bit timer with two compare channels and waveform generation:
// clear-on-compare, fast pwm and phase-correct pwm, apb register access
// assumes one clock domain (ref_clk); pin direction bits live in a register here
//
// Operation
// - mode 2 clears the counter when it equals compare A
// - mode 2 writes compare A directly; missed match wraps through 0xFF
// - mode 2 with action 1 toggles output A on every match
// - mode 2 sets overflow flag when count passes MAX to zero
// - mode 2 raises compare A flag each time count reaches TOP
// - fast pwm is mode 3 or 7, TOP 0xFF or compare A
// - fast pwm clears counter on the tick after TOP
// - fast pwm action 2 clears on match, sets at bottom; 3 inverts
// - fast pwm sets overflow flag when count reaches TOP
// - pwm action 1 toggles A only with high mode bit; not B
// - fast pwm extremes: bottom gives spike, MAX gives constant level
// - fast pwm double-buffers compare values, toggle use included
// - phase pwm is mode 1 or 5, TOP 0xFF or compare A
// - phase pwm holds TOP for one tick then reverses direction
// - phase pwm action 2 clears on up match, sets on down match
// - phase pwm sets overflow flag when count reaches bottom
// - phase pwm compare at bottom low, at MAX high; inverted opposite
// - phase pwm forces symmetric transition at top when match was missed
// - waveform drives pin only when direction bit is output
// - counter advances on prescaled ticks: 1, 8, 64, 256, 1024
// - counter, output and buffer-load updates on ref_clk edges qualified by tick; register writes are not
// - compare buffering in pwm modes only; load at top
// - action zero leaves output state unchanged on match
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "tmwm_consts.vh"

module tmwm_timer (
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         wave_out_a,
   output reg         wave_out_a_oe,
   output reg         wave_out_b,
   output reg         wave_out_b_oe
);

   // ==========================================
   // registers
   reg  [11:0] ctrl;
   reg  [7:0]  count_value;
   reg  [7:0]  compare_a_value;
   reg  [7:0]  compare_b_value;
   reg  [7:0]  cmp_a_buf;
   reg  [7:0]  cmp_b_buf;
   reg         overflow_flag;
   reg         compare_a_flag;
   reg         compare_b_flag;
   reg  [1:0]  pin_dir;
   reg         state_a;
   reg         state_b;
   reg         count_down;
   reg  [9:0]  pre_cnt;
   reg         timer_tick;
   reg         cnt_wr_block;

   wire [2:0]  wave_mode_select   = ctrl[`TMWM_CTRL_MODE_HI:`TMWM_CTRL_MODE_LO];
   wire        wave_mode_high_bit = wave_mode_select[2];
   wire [2:0]  pre_sel            = ctrl[`TMWM_CTRL_PRE_HI:`TMWM_CTRL_PRE_LO];
   wire [1:0]  out_a_action       = ctrl[`TMWM_CTRL_ACTA_HI:`TMWM_CTRL_ACTA_LO];
   wire [1:0]  out_b_action       = ctrl[`TMWM_CTRL_ACTB_HI:`TMWM_CTRL_ACTB_LO];

   wire is_ctc  = (wave_mode_select == `TMWM_MODE_CTC);
   wire is_fast = (wave_mode_select == `TMWM_MODE_FAST_FF) || (wave_mode_select == `TMWM_MODE_FAST_CA);
   wire is_pc   = (wave_mode_select == `TMWM_MODE_PC_FF) || (wave_mode_select == `TMWM_MODE_PC_CA);
   wire is_pwm  = is_fast || is_pc;

   // ==========================================
   // apb access, zero wait states
   wire acc  = psel && penable;
   wire wr   = acc && pwrite;
   wire wr_ctrl  = wr && (paddr == `TMWM_OFF_CTRL);
   wire wr_count = wr && (paddr == `TMWM_OFF_COUNT);
   wire wr_cmpa  = wr && (paddr == `TMWM_OFF_CMPA);
   wire wr_cmpb  = wr && (paddr == `TMWM_OFF_CMPB);
   wire wr_flags = wr && (paddr == `TMWM_OFF_FLAGS);
   wire wr_dir   = wr && (paddr == `TMWM_OFF_DIR);
   wire mapped   = (paddr == `TMWM_OFF_CTRL) || (paddr == `TMWM_OFF_COUNT) ||
                   (paddr == `TMWM_OFF_CMPA) || (paddr == `TMWM_OFF_CMPB) ||
                   (paddr == `TMWM_OFF_FLAGS) || (paddr == `TMWM_OFF_DIR) ||
                   (paddr == `TMWM_OFF_WAVE);

   reg [31:0] next_prdata;
   always @* begin
      next_prdata = `TMWM_ZERO32;
      case (paddr)
         `TMWM_OFF_CTRL:  next_prdata[11:0] = ctrl;
         `TMWM_OFF_COUNT: next_prdata[7:0]  = count_value;
         `TMWM_OFF_CMPA:  next_prdata[7:0]  = is_pwm ? cmp_a_buf : compare_a_value;
         `TMWM_OFF_CMPB:  next_prdata[7:0]  = is_pwm ? cmp_b_buf : compare_b_value;
         `TMWM_OFF_FLAGS: next_prdata[2:0]  = {compare_b_flag, compare_a_flag, overflow_flag};
         `TMWM_OFF_DIR:   next_prdata[1:0]  = pin_dir;
         `TMWM_OFF_WAVE:  next_prdata[1:0]  = {state_b, state_a};
         default:         next_prdata       = `TMWM_ZERO32;
      endcase
   end

   // pready rises in the access cycle itself, so prdata must be ready by then
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata  <= `TMWM_ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? next_prdata : `TMWM_ZERO32;
      end
   end

   // ==========================================
   // prescaler
   reg next_tick;
   always @* begin
      case (pre_sel)
         `TMWM_PRE_1:    next_tick = 1'b1;
         `TMWM_PRE_8:    next_tick = ((pre_cnt & `TMWM_DIV_8) == `TMWM_DIV_8);
         `TMWM_PRE_64:   next_tick = ((pre_cnt & `TMWM_DIV_64) == `TMWM_DIV_64);
         `TMWM_PRE_256:  next_tick = ((pre_cnt & `TMWM_DIV_256) == `TMWM_DIV_256);
         `TMWM_PRE_1024: next_tick = (pre_cnt == `TMWM_DIV_1024);
         default:        next_tick = 1'b0;
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         pre_cnt    <= 10'h000;
         timer_tick <= 1'b0;
      end else begin
         pre_cnt    <= (pre_sel == `TMWM_PRE_STOP) ? 10'h000 : pre_cnt + 10'h001;
         timer_tick <= next_tick;
      end
   end

   // ==========================================
   // counter sequencing
   // top per mode: MAX or compare A
   wire [7:0] top_val = (wave_mode_select == `TMWM_MODE_PC_FF || wave_mode_select == `TMWM_MODE_FAST_FF ||
                         wave_mode_select == `TMWM_MODE_NORMAL) ? `TMWM_MAX : compare_a_value;
   wire at_top    = (count_value == top_val);
   wire at_bottom = (count_value == `TMWM_BOTTOM);
   wire match_a   = (count_value == compare_a_value) && !cnt_wr_block;
   wire match_b   = (count_value == compare_b_value) && !cnt_wr_block;

   reg [7:0] next_count;
   reg       next_down;
   always @* begin
      next_count = count_value + 8'h01;
      next_down  = count_down;
      if (is_ctc) begin
         next_count = match_a ? `TMWM_BOTTOM : count_value + 8'h01;
      end else if (is_fast) begin
         next_count = at_top ? `TMWM_BOTTOM : count_value + 8'h01;
      end else if (is_pc) begin
         // one tick at TOP, then reverse
         if (!count_down && at_top) begin
            next_down  = 1'b1;
            next_count = count_value - 8'h01;
         end else if (count_down && at_bottom) begin
            next_down  = 1'b0;
            next_count = count_value + 8'h01;
         end else begin
            next_count = count_down ? count_value - 8'h01 : count_value + 8'h01;
         end
      end
   end

   // ==========================================
   // waveform state for one channel
   // up is the slope a match stands for: bottom counts as up, top as down,
   // which is what keeps the phase pwm extremes flat
   function wave_next;
      input       cur;
      input [1:0] act;
      input       match;
      input       tgl_ok;
      input       cmp_top;
      input       top_evt;
      input       up;
      begin
         wave_next = cur;
         if (act == `TMWM_ACT_NONE) begin
            wave_next = cur;
         end else if (is_pwm && act == `TMWM_ACT_TOGGLE) begin
            // toggle only with high mode bit
            if (tgl_ok && match)
               wave_next = !cur;
         end else if (!is_pwm) begin
            // toggle, clear or set on match
            if (match)
               wave_next = (act == `TMWM_ACT_TOGGLE) ? !cur : (act == `TMWM_ACT_SET);
         end else if (is_fast) begin
            // match level, then the opposite at bottom
            // compare at TOP ignores the match, level set at top
            if (top_evt)
               wave_next = (act == `TMWM_ACT_CLEAR);
            else if (match && !cmp_top)
               wave_next = (act == `TMWM_ACT_SET);
         end else begin
            // up match and down match act oppositely
            // bottom match counts as up, top match as down
            // at top the up-match level unless compare stays at top
            // covers a compare leaving MAX and a start above compare
            if (top_evt)
               wave_next = cmp_top ? (act == `TMWM_ACT_CLEAR) : (act == `TMWM_ACT_SET);
            else if (match)
               wave_next = up ? (act == `TMWM_ACT_SET) : (act == `TMWM_ACT_CLEAR);
         end
      end
   endfunction

   // one-tick events the waveform logic acts on
   wire       pc_top   = is_pc && !count_down && at_top;
   wire       fast_top = is_fast && at_top;
   wire       pc_up    = at_bottom || !count_down;
   // compares reload at top, so phase pwm judges the values about to load
   wire [7:0] next_top = (wave_mode_select == `TMWM_MODE_PC_CA) ? cmp_a_buf : `TMWM_MAX;
   wire       a_at_top = is_pc ? (cmp_a_buf == next_top) : (compare_a_value == top_val);
   wire       b_at_top = is_pc ? (cmp_b_buf == next_top) : (compare_b_value == top_val);

   reg next_a;
   reg next_b;
   always @* begin
      next_a = wave_next(state_a, out_a_action, match_a, wave_mode_high_bit, a_at_top,
                         fast_top || pc_top, pc_up);
      next_b = wave_next(state_b, out_b_action, match_b, 1'b0, b_at_top,
                         fast_top || pc_top, pc_up);
   end

   // ==========================================
   // main timer process
   // counter, output and buffer-load updates qualified by the tick; register writes are not
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl            <= 12'h000;
         count_value     <= `TMWM_BOTTOM;
         compare_a_value <= `TMWM_BOTTOM;
         compare_b_value <= `TMWM_BOTTOM;
         cmp_a_buf       <= `TMWM_BOTTOM;
         cmp_b_buf       <= `TMWM_BOTTOM;
         overflow_flag   <= 1'b0;
         compare_a_flag  <= 1'b0;
         compare_b_flag  <= 1'b0;
         pin_dir         <= 2'b00;
         state_a         <= 1'b0;
         state_b         <= 1'b0;
         count_down      <= 1'b0;
         cnt_wr_block    <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl <= pwdata[11:0];
         if (wr_dir)
            pin_dir <= pwdata[1:0];
         // pwm writes land in the buffer
         if (wr_cmpa)
            cmp_a_buf <= pwdata[7:0];
         if (wr_cmpb)
            cmp_b_buf <= pwdata[7:0];
         if (wr_cmpa && !is_pwm)
            compare_a_value <= pwdata[7:0];
         if (wr_cmpb && !is_pwm)
            compare_b_value <= pwdata[7:0];
         // a count write blocks the next tick's match
         if (wr_count)
            cnt_wr_block <= 1'b1;
         else if (timer_tick)
            cnt_wr_block <= 1'b0;

         if (wr_count) begin
            count_value <= pwdata[7:0];
         end else if (timer_tick) begin
            count_value <= next_count;
            count_down  <= is_pc ? next_down : 1'b0;
            state_a     <= next_a;
            state_b     <= next_b;
            // buffer load at top (fast, phase) of the sequence
            if (is_pwm && ((is_fast && at_top) || pc_top)) begin
               compare_a_value <= cmp_a_buf;
               compare_b_value <= cmp_b_buf;
            end
         end

         // flags: hardware set wins over software clear
         // overflow on MAX to zero in ctc/normal
         // overflow at TOP in fast pwm
         // overflow at bottom in phase pwm
         if (timer_tick && !wr_count &&
             (((is_ctc || wave_mode_select == `TMWM_MODE_NORMAL) && count_value == `TMWM_MAX) ||
              (is_fast && at_top) || (is_pc && count_down && at_bottom)))
            overflow_flag <= 1'b1;
         else if (wr_flags && pwdata[`TMWM_FLG_OVF])
            overflow_flag <= 1'b0;
         // compare A flag each period in ctc
         if (timer_tick && !wr_count && match_a)
            compare_a_flag <= 1'b1;
         else if (wr_flags && pwdata[`TMWM_FLG_CMPA])
            compare_a_flag <= 1'b0;
         if (timer_tick && !wr_count && match_b)
            compare_b_flag <= 1'b1;
         else if (wr_flags && pwdata[`TMWM_FLG_CMPB])
            compare_b_flag <= 1'b0;
      end
   end

   // ==========================================
   // pin drive
   // drive only when direction is output
   // data lags the state and enable lags the direction and action bits, each by one clock
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         wave_out_a    <= 1'b0;
         wave_out_b    <= 1'b0;
         wave_out_a_oe <= 1'b0;
         wave_out_b_oe <= 1'b0;
      end else begin
         wave_out_a    <= state_a;
         wave_out_b    <= state_b;
         wave_out_a_oe <= pin_dir[0] && (out_a_action != `TMWM_ACT_NONE);
         wave_out_b_oe <= pin_dir[1] && (out_b_action != `TMWM_ACT_NONE);
      end
   end

endmodule

// file: tb/tmwm_monitor.sv
// port-level checker for the timer waveform block
// assumes a bind into tmwm_timer, one clock and a sync active-high reset
`timescale 1ns/1ps
module tmwm_monitor (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        wave_out_a,
   input wire        wave_out_a_oe,
   input wire        wave_out_b,
   input wire        wave_out_b_oe
);
   reg [2:0] since_wr;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================
   // cycles since the last accepted write
   always @(posedge ref_clk) begin
      if (sys_rst || (psel && penable && pready && pwrite)) begin
         since_wr <= 3'h0;
      end else if (since_wr != 3'h7) begin
         since_wr <= since_wr + 3'h1;
      end
   end

   // ==========================================
   // bus and pin relations
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_error_unmapped: assert property (pready && paddr >= 12'h01C |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (pready && paddr < 12'h01C && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   a_read_data_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
      else $error("read data outside read");
   a_reset_clears: assert property (disable iff (1'b0)
      sys_rst |=> !pready && !wave_out_a && !wave_out_b && !wave_out_a_oe && !wave_out_b_oe)
      else $error("outputs not cleared by reset");
   // enables only follow register writes, never the waveform itself
   a_pin_after_write: assert property ($changed({wave_out_a_oe, wave_out_b_oe}) |-> since_wr <= 3'h2)
      else $error("pin enable changed without write");
endmodule

bind tmwm_timer tmwm_monitor u_monitor (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_out_a(wave_out_a),
   .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe));

// file: tb/tmwm_timer_test.sv
// self-checking bench for the timer waveform block over apb
// assumes prescale /1 gives one tick per ref_clk cycle
`timescale 1ns/1ps
`include "tmwm_consts.vh"
module tmwm_timer_test;
   reg         ref_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         psel    = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite  = 1'b0;
   reg  [11:0] paddr   = 12'h000;
   reg  [31:0] pwdata  = 32'h0000_0000;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        wave_out_a;
   wire        wave_out_a_oe;
   wire        wave_out_b;
   wire        wave_out_b_oe;
   reg  [31:0] rd;
   reg         err;
   reg  [11:0] addr;
   integer     hi;
   integer     lo;
   integer     mismatches  = 0;
   integer     comparisons = 0;

   always #4 ref_clk = ~ref_clk;

   tmwm_timer dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
      .wave_out_b_oe(wave_out_b_oe));

   // ==========================================
   // bus and compare tasks
   task check(input [31:0] got, input [31:0] exp, input string what);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // look mid-cycle where pready has settled; the next edge takes the transfer
      @(negedge ref_clk);
      while (pready !== 1'b1)
         @(negedge ref_clk);
      rd = prdata;
      err = pslverr;
      @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ==========================================
   // setup and waveform measurement
   // reset between set-ups so no old buffer or output state leaks over
   task cfg(input [2:0] m, input [1:0] aa, input [1:0] ab, input [7:0] ca, input [7:0] cnt);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      apb(1'b1, `TMWM_OFF_COUNT, {24'h00_0000, cnt});
      apb(1'b1, `TMWM_OFF_CMPA, {24'h00_0000, ca});
      apb(1'b1, `TMWM_OFF_CMPB, 32'h0000_0001);
      apb(1'b1, `TMWM_OFF_DIR, 32'h0000_0003);
      apb(1'b1, `TMWM_OFF_CTRL, {20'h0_0000, aa, ab, 1'b0, `TMWM_PRE_1, 1'b0, m});
   endtask

   task run_until(input lvl, output integer k);
      k = 0;
      while (wave_out_a !== lvl && k < 3000) begin
         @(negedge ref_clk);
         k = k + 1;
      end
      if (k >= 3000) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: level never reached", $time);
      end
   endtask

   task measure;
      integer k;
      run_until(1'b0, k);
      run_until(1'b1, k);
      run_until(1'b0, hi);
      run_until(1'b1, lo);
   endtask

   task steady(input sel, input lvl);
      integer k;
      k = 0;
      repeat (1100) @(posedge ref_clk);
      repeat (600) begin
         @(negedge ref_clk);
         if ((sel ? wave_out_b : wave_out_a) !== lvl) k = k + 1;
      end
      check(k, 0, "steady level");
   endtask

   // l of zero means a constant output at level h
   task row(input [2:0] m, input [1:0] a, input [7:0] c, input integer h, input integer l);
      cfg(m, a, 2'b00, c, 8'h00);
      if (l == 0) begin
         steady(1'b0, h[0]);
      end else begin
         measure;
         measure;
         check(hi, h, "high ticks");
         check(lo, l, "low ticks");
      end
      check(wave_out_a_oe, a != 2'b00, "pin enable");
      apb(1'b0, `TMWM_OFF_FLAGS, 32'h0000_0000);
      check(rd[0], m != 3'd2, "overflow flag");
      $display("row mode %0d action %0d compare %0h done", m, a, c);
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================
   // test sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (addr = 12'h000; addr <= 12'h018; addr = addr + 12'h004) begin
         apb(1'b0, addr, 32'h0000_0000);
         check(rd, 32'h0000_0000, "reset value");
      end
      apb(1'b0, 12'h01C, 32'h0000_0000);
      check(err, 1'b1, "unmapped refused");
      $display("test reset values done");

      cfg(3'd2, 2'd1, 2'd0, 8'h05, 8'h0A);
      apb(1'b0, `TMWM_OFF_COUNT, 32'h0000_0000);
      check(rd > 32'd5, 1'b1, "count past compare");
      repeat (300) @(posedge ref_clk);
      apb(1'b0, `TMWM_OFF_FLAGS, 32'h0000_0000);
      check(rd[1:0], 2'b11, "wrap flags");
      apb(1'b1, `TMWM_OFF_FLAGS, 32'h0000_0007);
      repeat (50) @(posedge ref_clk);
      apb(1'b0, `TMWM_OFF_FLAGS, 32'h0000_0000);
      check(rd[1:0], 2'b10, "period flags");
      repeat (6) begin
         apb(1'b0, `TMWM_OFF_COUNT, 32'h0000_0000);
         check(rd <= 32'd5, 1'b1, "count ceiling");
      end
      apb(1'b1, `TMWM_OFF_DIR, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      check(wave_out_a_oe, 1'b0, "pin released");
      $display("test clear on compare done");

      row(3'd2, 2'd1, 8'h03, 4, 4);
      row(3'd3, 2'd2, 8'h40, 65, 191);
      row(3'd3, 2'd3, 8'h40, 191, 65);
      row(3'd7, 2'd1, 8'h03, 4, 4);
      row(3'd3, 2'd1, 8'h03, 0, 0);
      row(3'd3, 2'd2, 8'h00, 1, 255);
      row(3'd3, 2'd2, 8'hFF, 1, 0);
      row(3'd1, 2'd2, 8'h40, 128, 382);
      row(3'd1, 2'd3, 8'h40, 382, 128);
      row(3'd1, 2'd2, 8'h00, 0, 0);
      row(3'd1, 2'd3, 8'h00, 1, 0);
      row(3'd2, 2'd0, 8'h03, 0, 0);

      cfg(3'd7, 2'd1, 2'd1, 8'h03, 8'h00);
      steady(1'b1, 1'b0);
      $display("test channel b toggle done");
      tally_and_finish;
   end

   // ==========================================
   // watchdog
   initial begin
      #780_000;
      mismatches = mismatches + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish;
   end
endmodule
